// [hdl/ncds_top.sv]
`timescale 1ns/100ps
module ncds_top import ncds_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic soft_reset,
    // host register port
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_data,
    input wire logic diag_rd,
    output logic [7:0] diag_data,
    // line pin
    input wire logic line_receive_input,
    // protocol core events
    input wire logic chaining_en,
    input wire logic token_to_me,
    input wire logic token_timeout,
    input wire logic foreign_token,
    input wire logic tx_started,
    input wire logic tx_done,
    input wire logic ack_received,
    input wire logic rx_arriving,
    input wire logic rx_done_ok,
    input wire logic [7:0] rx_dest_id,
    input wire logic rx_for_me,
    input wire logic por_event,
    input wire logic rebuild_event,
    // status toward the host
    output logic transmitter_available,
    output logic tx_acked,
    output logic receiver_inhibited,
    output logic por_flag,
    output logic network_rebuild_flag,
    // control toward the protocol core
    output logic tx_pending,
    output logic [1:0] tx_page,
    output logic [1:0] rx_page,
    output logic bcast_accept,
    output logic long_packets,
    output logic rx_accept,
    output logic rx_ack_send,
    output logic clr_tx_int,
    output logic clr_rx_int
);
    // ----------------------------------------
    // line input synchroniser and edge detect
    // ----------------------------------------
    logic line_sync;
    logic line_last_reg;
    logic line_last_next;

    ncds_sync u_line_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(line_receive_input),
        .sync_out(line_sync)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic self_reb_reg, self_reb_next;
    logic act_reg, act_next;
    logic tok_reg, tok_next;
    logic [7:0] diag_reg, diag_next;
    logic ta_reg, ta_next;
    logic tma_reg, tma_next;
    logic ri_reg, ri_next;
    logic por_reg, por_next;
    logic reb_reg, reb_next;
    logic txp_reg, txp_next;
    logic dis_tx_reg, dis_tx_next;
    logic dis_rx_reg, dis_rx_next;
    logic [1:0] txpg_reg, txpg_next;
    logic [1:0] rxpg_reg, rxpg_next;
    logic bc_reg, bc_next;
    logic long_reg, long_next;
    logic ack_reg, ack_next;
    logic cti_reg, cti_next;
    logic cri_reg, cri_next;
    logic acc_reg, acc_next;

    // decoded command strobes, valid only in the write cycle
    logic wr_send, wr_accept, wr_len, wr_flags;
    logic rx_bcast;
    logic rx_take;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    // decode happens only under cmd_wr so a held bus value acts once
    always_comb begin
        wr_send = cmd_wr && ((cmd_data & NCDS_MASK_SEND) == NCDS_CODE_SEND);
        wr_accept = cmd_wr && ((cmd_data & NCDS_MASK_ACCEPT) == NCDS_CODE_ACCEPT);
        wr_len = cmd_wr && ((cmd_data & NCDS_MASK_LEN) == NCDS_CODE_LEN);
        wr_flags = cmd_wr && ((cmd_data & NCDS_MASK_FLAGS) == NCDS_CODE_FLAGS);
        rx_bcast = (rx_dest_id == NCDS_BCAST_ID);
        // inhibited receiver drops everything; broadcast only when allowed
        rx_take = !ri_reg && (rx_for_me || (rx_bcast && bc_reg));
    end

    // ----------------------------------------
    // diagnostic status
    // ----------------------------------------
    // diagnostic bits: a set in the read cycle survives the clear
    always_comb begin
        line_last_next = line_sync;
        self_reb_next = self_reb_reg;
        act_next = act_reg;
        tok_next = tok_reg;
        if (diag_rd || soft_reset) begin
            self_reb_next = 1'b0;
            act_next = 1'b0;
            tok_next = 1'b0;
        end
        if (token_timeout) begin
            self_reb_next = 1'b1;
        end
        if (line_sync != line_last_reg) begin
            act_next = 1'b1;
        end
        if (foreign_token) begin
            tok_next = 1'b1;
        end
        diag_next = diag_reg;
        // soft reset also blanks the captured value the host sees
        if (soft_reset) begin
            diag_next = NCDS_DIAG_RESET;
        end
        if (diag_rd) begin
            // undefined bits read as zero
            diag_next = NCDS_DIAG_RESET;
            diag_next[NCDS_DIAG_SELF_BIT] = self_reb_reg;
            diag_next[NCDS_DIAG_ACT_BIT] = act_reg;
            diag_next[NCDS_DIAG_TOKEN_BIT] = tok_reg;
        end
    end

    // ----------------------------------------
    // transmit status
    // ----------------------------------------
    // transmit side
    always_comb begin
        ta_next = ta_reg;
        tma_next = tma_reg;
        txp_next = txp_reg;
        dis_tx_next = dis_tx_reg;
        txpg_next = txpg_reg;
        cti_next = 1'b0;
        if (cmd_wr && cmd_data == NCDS_CMD_CLR_TX_INT && chaining_en) begin
            cti_next = 1'b1;
        end
        if (cmd_wr && cmd_data == NCDS_CMD_DIS_TX) begin
            // only a send that has not started can be withdrawn
            if (!tx_started) begin
                txp_next = 1'b0;
            end
            dis_tx_next = 1'b1;
        end
        if (dis_tx_reg && token_to_me) begin
            ta_next = 1'b1;
            dis_tx_next = 1'b0;
        end
        if (ack_received) begin
            tma_next = 1'b1;
        end
        if (tx_done) begin
            ta_next = 1'b1;
            txp_next = 1'b0;
        end
        if (wr_send) begin
            ta_next = 1'b0;
            tma_next = 1'b0;
            txp_next = 1'b1;
            dis_tx_next = 1'b0;
            txpg_next = cmd_data[NCDS_PAGE_LSB +: 2];
        end
    end

    // ----------------------------------------
    // receive status and configuration
    // ----------------------------------------
    // receive side and configuration
    always_comb begin
        ri_next = ri_reg;
        dis_rx_next = dis_rx_reg;
        rxpg_next = rxpg_reg;
        bc_next = bc_reg;
        long_next = long_reg;
        ack_next = 1'b0;
        cri_next = 1'b0;
        por_next = por_reg;
        reb_next = reb_reg;
        if (cmd_wr && cmd_data == NCDS_CMD_CLR_RX_INT && chaining_en) begin
            cri_next = 1'b1;
        end
        if (cmd_wr && cmd_data == NCDS_CMD_DIS_RX) begin
            dis_rx_next = 1'b1;
        end
        // reception under way finishes before the disable takes hold
        if (dis_rx_reg && token_to_me && !rx_arriving) begin
            ri_next = 1'b1;
            dis_rx_next = 1'b0;
        end
        if (rx_done_ok && rx_take) begin
            ri_next = 1'b1;
            // broadcasts are never acknowledged
            ack_next = !rx_bcast;
        end
        if (wr_accept) begin
            ri_next = 1'b0;
            dis_rx_next = 1'b0;
            rxpg_next = cmd_data[NCDS_PAGE_LSB +: 2];
            bc_next = cmd_data[NCDS_BCAST_BIT];
        end
        if (wr_len) begin
            long_next = cmd_data[NCDS_LONG_BIT];
        end
        if (wr_flags && cmd_data[NCDS_POR_CLR_BIT]) begin
            por_next = 1'b0;
        end
        if (wr_flags && cmd_data[NCDS_REB_CLR_BIT]) begin
            reb_next = 1'b0;
        end
        // hardware set beats a clear in the same cycle
        if (por_event || soft_reset) begin
            por_next = 1'b1;
        end
        if (rebuild_event) begin
            reb_next = 1'b1;
        end
        // registered copy so the accept output needs no gate after the flop
        acc_next = !ri_next;
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    // register everything; hardware reset clears diagnostics
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_last_reg <= 1'b0;
            self_reb_reg <= 1'b0;
            act_reg <= 1'b0;
            tok_reg <= 1'b0;
            diag_reg <= NCDS_DIAG_RESET;
            ta_reg <= NCDS_TA_RESET;
            tma_reg <= 1'b0;
            ri_reg <= NCDS_RI_RESET;
            por_reg <= NCDS_POR_RESET;
            reb_reg <= 1'b0;
            txp_reg <= 1'b0;
            dis_tx_reg <= 1'b0;
            dis_rx_reg <= 1'b0;
            txpg_reg <= 2'h0;
            rxpg_reg <= 2'h0;
            bc_reg <= 1'b0;
            long_reg <= NCDS_LONG_RESET;
            ack_reg <= 1'b0;
            cti_reg <= 1'b0;
            cri_reg <= 1'b0;
            acc_reg <= !NCDS_RI_RESET;
        end else begin
            line_last_reg <= line_last_next;
            self_reb_reg <= self_reb_next;
            act_reg <= act_next;
            tok_reg <= tok_next;
            diag_reg <= diag_next;
            ta_reg <= ta_next;
            tma_reg <= tma_next;
            ri_reg <= ri_next;
            por_reg <= por_next;
            reb_reg <= reb_next;
            txp_reg <= txp_next;
            dis_tx_reg <= dis_tx_next;
            dis_rx_reg <= dis_rx_next;
            txpg_reg <= txpg_next;
            rxpg_reg <= rxpg_next;
            bc_reg <= bc_next;
            long_reg <= long_next;
            ack_reg <= ack_next;
            cti_reg <= cti_next;
            cri_reg <= cri_next;
            acc_reg <= acc_next;
        end
    end

    // ----------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------
    assign diag_data = diag_reg;
    assign transmitter_available = ta_reg;
    assign tx_acked = tma_reg;
    assign receiver_inhibited = ri_reg;
    assign por_flag = por_reg;
    assign network_rebuild_flag = reb_reg;
    assign tx_pending = txp_reg;
    assign tx_page = txpg_reg;
    assign rx_page = rxpg_reg;
    assign bcast_accept = bc_reg;
    assign long_packets = long_reg;
    assign rx_accept = acc_reg;
    assign rx_ack_send = ack_reg;
    assign clr_tx_int = cti_reg;
    assign clr_rx_int = cri_reg;
endmodule // ncds_top

// [hdl/ncds_pkg.sv]
// Functional notes
// - token receive timeout sets self rebuild bit 7
// - line transitions set activity bit 5
// - foreign token seen sets bit 4
// - bits 6 and 3-0 read zero
// - diagnostic read or reset clears all bits
// - clear interrupt codes act only when chaining
// - disable transmitter cancels a send not yet started, sets available at token
// - disable receiver, inhibit at token if idle
// - send command clears available/acked, sends page
// - transmit end sets available, acked set before
// - acknowledge received packet in hardware first
// - accept command clears inhibited, sets page, broadcast
// - destination zero means broadcast
// - good receive into page sets inhibited
// - inhibited receiver accepts nothing until accept
// - length command selects long or short packets
// - clear flags clears power-on, rebuild independently
package ncds_pkg;
    // ----------------------------------------
    // diagnostic status bit positions
    // ----------------------------------------
    localparam int NCDS_DIAG_SELF_BIT = 7;
    localparam int NCDS_DIAG_ACT_BIT = 5;
    localparam int NCDS_DIAG_TOKEN_BIT = 4;
    localparam logic [7:0] NCDS_DIAG_RESET = 8'h00;
    // ----------------------------------------
    // command codes and masks
    // ----------------------------------------
    localparam logic [7:0] NCDS_CMD_CLR_TX_INT = 8'h00;
    localparam logic [7:0] NCDS_CMD_DIS_TX = 8'h01;
    localparam logic [7:0] NCDS_CMD_DIS_RX = 8'h02;
    localparam logic [7:0] NCDS_CMD_CLR_RX_INT = 8'h08;
    localparam logic [7:0] NCDS_MASK_SEND = 8'hE7;
    localparam logic [7:0] NCDS_CODE_SEND = 8'h03;
    localparam logic [7:0] NCDS_MASK_ACCEPT = 8'h67;
    localparam logic [7:0] NCDS_CODE_ACCEPT = 8'h04;
    localparam logic [7:0] NCDS_MASK_LEN = 8'hF7;
    localparam logic [7:0] NCDS_CODE_LEN = 8'h05;
    localparam logic [7:0] NCDS_MASK_FLAGS = 8'hE7;
    localparam logic [7:0] NCDS_CODE_FLAGS = 8'h06;
    // ----------------------------------------
    // command fields
    // ----------------------------------------
    localparam int NCDS_PAGE_LSB = 3;
    localparam int NCDS_BCAST_BIT = 7;
    localparam int NCDS_LONG_BIT = 3;
    localparam int NCDS_POR_CLR_BIT = 3;
    localparam int NCDS_REB_CLR_BIT = 4;
    localparam logic [7:0] NCDS_BCAST_ID = 8'h00;
    // ----------------------------------------
    // reset values of status bits
    // ----------------------------------------
    localparam logic NCDS_TA_RESET = 1'b1;
    localparam logic NCDS_RI_RESET = 1'b1;
    localparam logic NCDS_POR_RESET = 1'b1;
    localparam logic NCDS_LONG_RESET = 1'b0;
endpackage

// [hdl/ncds_sync.sv]
`timescale 1ns/100ps
module ncds_sync import ncds_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // async level in, synchronised out
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    // two stages; only the second stage is seen outside
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule // ncds_sync

// [dv/ncds_checker.sv]
`timescale 1ns/100ps
module ncds_checker import ncds_pkg::*; (
    // clock, reset, host port
    input wire logic core_clk,
    input wire logic rst,
    input wire logic soft_reset,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_data,
    input wire logic diag_rd,
    input wire logic [7:0] diag_data,
    // core events
    input wire logic chaining_en,
    input wire logic tx_started,
    input wire logic tx_done,
    input wire logic rx_done_ok,
    input wire logic [7:0] rx_dest_id,
    input wire logic rx_for_me,
    input wire logic rebuild_event,
    // status and control
    input wire logic transmitter_available,
    input wire logic tx_pending,
    input wire logic receiver_inhibited,
    input wire logic network_rebuild_flag,
    input wire logic [1:0] tx_page,
    input wire logic [1:0] rx_page,
    input wire logic bcast_accept,
    input wire logic long_packets,
    input wire logic rx_accept,
    input wire logic rx_ack_send,
    input wire logic clr_tx_int,
    input wire logic clr_rx_int
);
    // ----
    // decoded writes
    // ----
    wire logic [7:0] d = cmd_data;
    wire logic wr_send = cmd_wr && (d & NCDS_MASK_SEND) == NCDS_CODE_SEND;
    wire logic wr_acc = cmd_wr && (d & NCDS_MASK_ACCEPT) == NCDS_CODE_ACCEPT;
    wire logic wr_len = cmd_wr && (d & NCDS_MASK_LEN) == NCDS_CODE_LEN;
    wire logic wr_flg = cmd_wr && (d & NCDS_MASK_FLAGS) == NCDS_CODE_FLAGS;
    // chaining clears only count while chaining is on
    wire logic txc_due = cmd_wr && d == NCDS_CMD_CLR_TX_INT && chaining_en;
    wire logic rxc_due = cmd_wr && d == NCDS_CMD_CLR_RX_INT && chaining_en;
    // inhibited receiver must never acknowledge
    wire logic ack_due = rx_done_ok && rx_for_me && rx_dest_id != NCDS_BCAST_ID && !receiver_inhibited;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_txc; clr_tx_int == $past(txc_due); endproperty
    a_txc: assert property (p_txc) else $error("tx clear pulse wrong");
    property p_rxc; clr_rx_int == $past(rxc_due); endproperty
    a_rxc: assert property (p_rxc) else $error("rx clear pulse wrong");
    property p_send; wr_send |=> !transmitter_available && tx_pending && tx_page == $past(d[4:3]); endproperty
    a_send: assert property (p_send) else $error("send setup wrong");
    property p_acc; wr_acc && !rx_done_ok |=> !receiver_inhibited && rx_page == $past(d[4:3])
        && bcast_accept == $past(d[7]); endproperty
    a_acc: assert property (p_acc) else $error("accept setup wrong");
    property p_len; wr_len |=> long_packets == $past(d[3]); endproperty
    a_len: assert property (p_len) else $error("length mode wrong");
    property p_flg; wr_flg && d[4] && !rebuild_event |=> !network_rebuild_flag; endproperty
    a_flg: assert property (p_flg) else $error("rebuild flag kept");
    property p_done; tx_done && !cmd_wr |=> transmitter_available; endproperty
    a_done: assert property (p_done) else $error("available not set");
    property p_rsv; diag_data[6] == 1'b0 && diag_data[3:0] == 4'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("unused diag bit set");
    property p_ack; rx_ack_send == $past(ack_due); endproperty
    a_ack: assert property (p_ack) else $error("ack pulse wrong");
    property p_dtx; cmd_wr && d == NCDS_CMD_DIS_TX && !tx_started |=> !tx_pending; endproperty
    a_dtx: assert property (p_dtx) else $error("pending send not cancelled");
    property p_keep; cmd_wr && d == NCDS_CMD_DIS_TX && tx_started && tx_pending && !tx_done
        |=> tx_pending; endproperty
    a_keep: assert property (p_keep) else $error("started send cancelled");
    property p_inh; rx_done_ok && rx_for_me && !receiver_inhibited && !wr_acc
        |=> receiver_inhibited; endproperty
    a_inh: assert property (p_inh) else $error("receiver not inhibited");
    property p_hold; receiver_inhibited && !wr_acc |=> receiver_inhibited; endproperty
    a_hold: assert property (p_hold) else $error("inhibit dropped");
    property p_rxa; rx_accept != receiver_inhibited; endproperty
    a_rxa: assert property (p_rxa) else $error("accept output wrong");
    property p_srst; soft_reset && !diag_rd |=> diag_data == NCDS_DIAG_RESET; endproperty
    a_srst: assert property (p_srst) else $error("diag not cleared");
endmodule // ncds_checker
bind ncds_top ncds_checker chk (.core_clk(core_clk), .rst(rst), .soft_reset(soft_reset),
    .cmd_wr(cmd_wr), .cmd_data(cmd_data), .diag_rd(diag_rd), .diag_data(diag_data),
    .chaining_en(chaining_en), .tx_started(tx_started), .tx_done(tx_done),
    .rx_done_ok(rx_done_ok), .rx_dest_id(rx_dest_id), .rx_for_me(rx_for_me),
    .rebuild_event(rebuild_event), .transmitter_available(transmitter_available),
    .tx_pending(tx_pending), .receiver_inhibited(receiver_inhibited),
    .network_rebuild_flag(network_rebuild_flag), .tx_page(tx_page), .rx_page(rx_page),
    .bcast_accept(bcast_accept), .long_packets(long_packets), .rx_accept(rx_accept),
    .rx_ack_send(rx_ack_send), .clr_tx_int(clr_tx_int), .clr_rx_int(clr_rx_int));

// [dv/ncds_host.sv]
`timescale 1ns/100ps
module ncds_host (
    // clock
    input wire logic core_clk,
    // host strobes
    output logic cmd_wr = 1'b0,
    output logic [7:0] cmd_data = 8'h00,
    output logic diag_rd = 1'b0
);
    // one byte per strobe; a gap cycle keeps writes distinct
    task automatic wr(input logic [7:0] v);
        @(negedge core_clk);
        cmd_wr = 1'b1;
        cmd_data = v;
        @(negedge core_clk);
        cmd_wr = 1'b0;
        cmd_data = ~v; // released bus shows no stale byte
    endtask
    // read strobe, data lands one edge later
    task automatic rd();
        @(negedge core_clk);
        diag_rd = 1'b1;
        @(negedge core_clk);
        diag_rd = 1'b0;
    endtask
endmodule // ncds_host

// [dv/ncds_top_bench.sv]
`timescale 1ns/100ps
module ncds_top_bench;
    // ----
    // stimulus and results
    // ----
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic chaining_en = 1'b0;
    logic line_receive_input = 1'b0;
    logic rx_for_me = 1'b0;
    logic tx_started = 1'b0;
    logic rx_arriving = 1'b0;
    logic [7:0] rx_dest_id = 8'h00;
    logic [8:0] ev = 9'h000;
    logic look = 1'b0;
    logic look_q = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] r = 8'h61;
    logic [1:0] p, q;
    logic [10:0] exp_q[$];
    logic [10:0] e;
    int errors = 0;
    int checks = 0;
    wire logic cmd_wr, diag_rd, tx_pending, rx_accept, rx_ack_send, clr_tx_int, clr_rx_int;
    wire logic transmitter_available, tx_acked, receiver_inhibited, por_flag;
    wire logic network_rebuild_flag, bcast_accept, long_packets;
    wire logic [7:0] cmd_data, diag_data;
    wire logic [1:0] tx_page, rx_page;
    wire logic [10:0] st = {transmitter_available, tx_acked, receiver_inhibited, por_flag,
        network_rebuild_flag, tx_page, rx_page, bcast_accept, long_packets};
    wire logic [10:0] got = rd_q ? {3'b000, diag_data} : st;
    ncds_host host (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
        .diag_rd(diag_rd));
    ncds_top dut (.core_clk(core_clk), .rst(rst), .soft_reset(ev[8]), .cmd_wr(cmd_wr),
        .cmd_data(cmd_data), .diag_rd(diag_rd), .diag_data(diag_data),
        .line_receive_input(line_receive_input), .chaining_en(chaining_en),
        .token_to_me(ev[0]), .token_timeout(ev[1]), .foreign_token(ev[2]),
        .tx_started(tx_started), .tx_done(ev[3]), .ack_received(ev[4]),
        .rx_arriving(rx_arriving), .rx_done_ok(ev[5]), .rx_dest_id(rx_dest_id),
        .rx_for_me(rx_for_me), .por_event(ev[6]), .rebuild_event(ev[7]),
        .transmitter_available(transmitter_available), .tx_acked(tx_acked),
        .receiver_inhibited(receiver_inhibited), .por_flag(por_flag),
        .network_rebuild_flag(network_rebuild_flag), .tx_pending(tx_pending),
        .tx_page(tx_page), .rx_page(rx_page), .bcast_accept(bcast_accept),
        .long_packets(long_packets), .rx_accept(rx_accept), .rx_ack_send(rx_ack_send),
        .clr_tx_int(clr_tx_int), .clr_rx_int(clr_rx_int));
    initial forever #20 core_clk = ~core_clk;
    // remember which result is due at the next falling edge
    always @(posedge core_clk) begin
        rd_q <= diag_rd;
        look_q <= look;
    end
    // compare each due result with the oldest note
    always @(negedge core_clk) begin
        if (rd_q || look_q) begin
            e = exp_q.pop_front();
            checks++;
            if (got !== e) begin
                errors++;
                $display("wrong value at %0t: got %h expected %h", $time, got, e);
            end
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic pulse(input logic [8:0] m);
        @(negedge core_clk);
        ev = m;
        @(negedge core_clk);
        ev = 9'h000;
    endtask
    task automatic chk(input logic [10:0] v);
        @(negedge core_clk);
        exp_q.push_back(v);
        look = 1'b1;
        @(negedge core_clk);
        look = 1'b0;
    endtask
    task automatic rdx(input logic [7:0] v);
        exp_q.push_back({3'b000, v});
        host.rd();
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the roughly 130 cycles used
    initial begin
        #100000;
        errors++;
        end_sim();
    end
    // status order: ta tma ri por rebuild, tx page, rx page, bcast, long
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        r = lfsr(r);
        p = r[1:0];
        r = lfsr(r);
        q = r[1:0];
        rdx(8'h00);
        chk({5'b10110, 6'h00});
        host.wr({3'b000, p, 3'b011});
        chk({5'b00110, p, 4'h0});
        pulse(9'h010);
        pulse(9'h008);
        chk({5'b11110, p, 4'h0});
        host.wr({3'b100, q, 3'b100});
        chk({5'b11010, p, q, 2'b10});
        pulse(9'h020);
        chk({5'b11110, p, q, 2'b10});
        host.wr(8'h0D);
        chk({5'b11110, p, q, 2'b11});
        pulse(9'h080);
        host.wr(8'h0E);
        chk({5'b11101, p, q, 2'b11});
        host.wr(8'h16);
        host.wr(8'h05);
        chk({5'b11100, p, q, 2'b10});
        host.wr({3'b000, p, 3'b011});
        host.wr(8'h01);
        pulse(9'h001);
        chk({5'b10100, p, q, 2'b10});
        // a send already on the wire survives the disable
        host.wr({3'b000, p, 3'b011});
        tx_started = 1'b1;
        host.wr(8'h01);
        pulse(9'h009);
        tx_started = 1'b0;
        chk({5'b10100, p, q, 2'b10});
        host.wr({3'b000, q, 3'b100});
        host.wr(8'h02);
        pulse(9'h001);
        chk({5'b10100, p, q, 2'b00});
        // a packet under way delays the inhibit to a later token
        host.wr({3'b000, q, 3'b100});
        rx_arriving = 1'b1;
        host.wr(8'h02);
        pulse(9'h001);
        chk({5'b10000, p, q, 2'b00});
        rx_arriving = 1'b0;
        pulse(9'h001);
        chk({5'b10100, p, q, 2'b00});
        host.wr({3'b000, q, 3'b100});
        rx_dest_id = r | 8'h01;
        rx_for_me = 1'b1;
        pulse(9'h020);
        pulse(9'h020);
        chk({5'b10100, p, q, 2'b00});
        for (int c = 0; c < 2; c++) begin
            chaining_en = c[0];
            host.wr(8'h00);
            host.wr(8'h08);
        end
        pulse(9'h006);
        line_receive_input = ~line_receive_input;
        repeat (6) @(negedge core_clk);
        rdx(8'hB0);
        rdx(8'h00);
        pulse(9'h002);
        pulse(9'h100);
        rdx(8'h00);
        chk({5'b10110, p, q, 2'b00});
        host.wr(8'h0E);
        chk({5'b10100, p, q, 2'b00});
        pulse(9'h040);
        chk({5'b10110, p, q, 2'b00});
        end_sim();
    end
endmodule // ncds_top_bench
